/* File: hw/tnr_receiver.sv */
// Purpose: TDM network-mode serial receiver with AXI4-Lite registers
// Assumes: Bit clock well below aclk/4; pins asynchronous to aclk
// Notes: Transmit side only framed here, to time its word request
// How it works
// - Receiver runs only with port_enable and rx_on
// - After rx_on, wait for a frame boundary
// - Every bit of every slot is captured
// - Sample data on falling bit clock edges
// - Word boundary copies shift register to data
// - Standard timing: frame starts at sync rise
// - Word available flag set each word
// - Receive interrupt when enabled and word available
// - Reading data clears flag and interrupt
// - Unread slot flags overrun at slot end
// - Asynchronous mode uses separate receive clock, sync
// - Lockstep mode uses the transmit clock, sync
// - lockstep_select chooses synchronous or asynchronous mode
// - Receive and transmit interrupt sources are separate
// - Receive event half bit before transmit word
// - Masked slot: no transfer, flags, interrupts
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module tnr_receiver import tnr_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_bit_clock,
   input wire logic rx_frame_sync,
   input wire logic rx_data_pin,
   input wire logic tx_bit_clock,
   input wire logic tx_frame_sync,
   output logic irq
);
   // Software state
   logic [CTRL_BITS-1:0] control_two;
   logic [EVT_BITS-1:0] irq_status;
   logic [EVT_BITS-1:0] irq_mask;
   logic [MAX_SLOTS-1:0] rx_slot_mask;
   logic [SLOT_W-1:0] slots_m1;
   logic [31:0] rx_data_reg;
   logic rx_word_avail;
   // Serial state
   logic [WORD_BITS-1:0] rx_shift_reg;
   logic [BIT_W-1:0] bit_cnt;
   logic [SLOT_W-1:0] slot;
   logic armed;
   logic fs_prev;
   logic early_pend;
   logic tx_fs_prev;
   logic [BIT_W-1:0] tx_bit_cnt;
   // Bus state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Pins resynchronised, then edges found on the second stage
   tnr_pins_t pins_raw;
   tnr_pins_t pins_s;
   tnr_pins_t pins_rise;
   tnr_pins_t pins_fall;
   assign pins_raw = '{tx_fs: tx_frame_sync, tx_clk: tx_bit_clock, rx_fs: rx_frame_sync,
                       rx_clk: rx_bit_clock, rx_data: rx_data_pin};
   tnr_sync #(.W(PIN_W)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );
   tnr_edge #(.W(PIN_W)) u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(pins_s),
      .rise(pins_rise),
      .fall(pins_fall)
   );

   // Control fields
   wire port_enable = control_two[B_PORT_ENABLE];
   wire rx_on = control_two[B_RX_ON];
   wire lockstep_select = control_two[B_LOCKSTEP];
   wire rx_irq_enable = control_two[B_RX_IRQ_EN];
   wire rx_sync_invert = control_two[B_SYNC_INVERT];
   wire rx_sync_early = control_two[B_SYNC_EARLY];
   wire rx_enabled = port_enable & rx_on;

   // Clock and sync source; lockstep borrows the transmit pair
   wire sel_fall = lockstep_select ? pins_fall.tx_clk : pins_fall.rx_clk;
   wire sel_fs = lockstep_select ? pins_s.tx_fs : pins_s.rx_fs;

   // Frame boundary; sync length needs no logic since only the rise counts
   wire fs_now = sel_fs ^ rx_sync_invert;
   wire fs_rise = fs_now & ~fs_prev;
   wire start_bit = rx_sync_early ? early_pend : fs_rise;
   wire last_bit = (bit_cnt == BIT_W'(WORD_BITS - 1));
   wire word_evt = sel_fall & armed & last_bit & ~start_bit;
   wire slot_on = rx_slot_mask[slot];
   wire take = word_evt & slot_on;
   wire [WORD_BITS-1:0] next_shift = {rx_shift_reg[WORD_BITS-2:0], pins_s.rx_data};
   wire [SLOT_W-1:0] next_slot = (slot == slots_m1) ? '0 : slot + 1'b1;
   wire frame_start_flag = armed & (slot == '0);

   // Falling bit clock: shift every bit, track frame position
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_shift_reg <= '0;
         fs_prev <= 1'b0;
         early_pend <= 1'b0;
      end else if (sel_fall) begin
         rx_shift_reg <= next_shift;
         fs_prev <= fs_now;
         early_pend <= fs_rise;
      end
   end

   // Arming waits for a fresh boundary after enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed <= 1'b0;
      end else if (!rx_enabled) begin
         armed <= 1'b0;
      end else if (sel_fall && start_bit) begin
         armed <= 1'b1;
      end
   end

   // Bit and slot counters; first bit of a frame already captured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_cnt <= '0;
         slot <= '0;
      end else if (sel_fall && start_bit) begin
         bit_cnt <= BIT_W'(1);
         slot <= '0;
      end else if (sel_fall && armed) begin
         bit_cnt <= last_bit ? '0 : bit_cnt + 1'b1;
         slot <= last_bit ? next_slot : slot;
      end
   end

   // Transmit framing, only to time the transmit word request
   wire tx_fs_rise = pins_s.tx_fs & ~tx_fs_prev;
   wire tx_word_evt = pins_rise.tx_clk & port_enable & (tx_fs_rise | tx_bit_cnt == '0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_fs_prev <= 1'b0;
         tx_bit_cnt <= '0;
      end else if (pins_rise.tx_clk) begin
         tx_fs_prev <= pins_s.tx_fs;
         tx_bit_cnt <= tx_fs_rise ? BIT_W'(1) : tx_bit_cnt + 1'b1;
      end
   end

   // Bus decode
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_go = aw_held & w_held & ~s_axi_bvalid;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire rd_hit = ar_take & (s_axi_araddr == OFF_RX_DATA);
   wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] wr_merge_ctrl = ({25'h0, control_two} & ~strb_mask) | (w_data & strb_mask);
   wire [31:0] wr_ones = w_data & strb_mask;
   wire wr_ctrl = wr_go & (aw_addr == OFF_CONTROL_TWO);
   wire wr_w1c = wr_go & (aw_addr == OFF_IRQ_STATUS);
   wire wr_mask = wr_go & (aw_addr == OFF_IRQ_MASK);
   wire wr_slot = wr_go & (aw_addr == OFF_RX_SLOT_MASK);
   wire wr_cfg = wr_go & (aw_addr == OFF_FRAME_CFG);
   wire wr_known = wr_ctrl | wr_w1c | wr_mask | wr_slot | wr_cfg;
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;

   // Write address and data latch independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response raised on the same clock edge as the register update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_two <= CTRL_RST;
         irq_mask <= '0;
         rx_slot_mask <= SLOT_MASK_RST;
         slots_m1 <= SLOTS_M1_RST;
      end else begin
         if (wr_ctrl) control_two <= wr_merge_ctrl[CTRL_BITS-1:0];
         if (wr_mask && w_strb[0]) irq_mask <= w_data[EVT_BITS-1:0];
         if (wr_slot && w_strb[0]) rx_slot_mask <= w_data[MAX_SLOTS-1:0];
         if (wr_cfg && w_strb[0]) slots_m1 <= w_data[SLOT_W-1:0];
      end
   end

   // Word transfer and word-available flag; a new word beats a read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data_reg <= 32'h0;
         rx_word_avail <= 1'b0;
      end else if (take) begin
         rx_data_reg <= {{(32 - WORD_BITS){1'b0}}, next_shift};
         rx_word_avail <= 1'b1;
      end else if (rd_hit) begin
         rx_word_avail <= 1'b0;
      end
   end

   // Sticky events; a set in the clearing cycle survives
   wire [EVT_BITS-1:0] evt_set;
   assign evt_set[E_OVERRUN] = take & rx_word_avail & ~rd_hit;
   assign evt_set[E_FRAME] = sel_fall & start_bit & rx_enabled;
   assign evt_set[E_TX_WORD] = tx_word_evt;
   wire [EVT_BITS-1:0] evt_clr = wr_w1c && w_strb[0] ? wr_ones[EVT_BITS-1:0] : '0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~evt_clr) | evt_set;
      end
   end

   // Receive source and event sources stay separate up to the pin
   wire rx_irq_src = rx_irq_enable & rx_word_avail;
   assign irq = rx_irq_src | (|(irq_status & irq_mask));

   // Read mux
   wire [31:0] stat_word = {20'h0, 1'b0, slot, 5'h0, armed, frame_start_flag, rx_word_avail};
   wire rd_known = s_axi_araddr inside {OFF_CONTROL_TWO, OFF_CONTROL_STATUS, OFF_RX_DATA,
                   OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_RX_SLOT_MASK, OFF_FRAME_CFG};
   wire [31:0] rd_mux =
      (s_axi_araddr == OFF_CONTROL_TWO) ? {25'h0, control_two} :
      (s_axi_araddr == OFF_CONTROL_STATUS) ? stat_word :
      (s_axi_araddr == OFF_RX_DATA) ? rx_data_reg :
      (s_axi_araddr == OFF_IRQ_STATUS) ? {29'h0, irq_status} :
      (s_axi_araddr == OFF_IRQ_MASK) ? {29'h0, irq_mask} :
      (s_axi_araddr == OFF_RX_SLOT_MASK) ? {24'h0, rx_slot_mask} :
      (s_axi_araddr == OFF_FRAME_CFG) ? {29'h0, slots_m1} : 32'h0;

   // Read data registered; one read in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_rx_gated_off: assert property (!rx_enabled |=> !armed)
      else $error("receiver armed while disabled");
   a_arm_on_boundary: assert property (!armed ##1 armed |-> $past(sel_fall && start_bit))
      else $error("receiver armed without frame boundary");
   a_sync_rise_start: assert property (sel_fall && start_bit && !rx_sync_early |-> fs_rise)
      else $error("frame started without sync rise");
   a_shift_sample: assert property (sel_fall |=> rx_shift_reg[0] == $past(pins_s.rx_data))
      else $error("data bit not shifted on falling edge");
   a_word_copy: assert property (take |=> rx_data_reg[WORD_BITS-1:0] == $past(next_shift))
      else $error("word not copied at boundary");
   a_avail_set: assert property (take |=> rx_word_avail)
      else $error("word available not set");
   a_rx_irq: assert property (rx_word_avail && rx_irq_enable |-> irq)
      else $error("receive interrupt missing");
   a_read_clears: assert property (rd_hit && !take |=> !rx_word_avail && (irq == |(irq_status & irq_mask)))
      else $error("data read did not clear flag");
   a_overrun_flag: assert property (take && rx_word_avail && !rd_hit |=> irq_status[E_OVERRUN])
      else $error("overrun not flagged");
   a_masked_slot: assert property (word_evt && !slot_on && !rd_hit |=> $stable(rx_data_reg) && $stable(rx_word_avail))
      else $error("masked slot changed state");
   a_lockstep_src: assert property (lockstep_select |-> sel_fall == pins_fall.tx_clk)
      else $error("lockstep not on transmit clock");
   // Frame event must reach the sticky status even if cleared that cycle
   a_frame_event: assert property (sel_fall && start_bit && rx_enabled |=> irq_status[E_FRAME])
      else $error("frame start event lost");
   // In lockstep the two word events must never share a cycle
   a_rx_tx_apart: assert property (lockstep_select && take |-> !tx_word_evt)
      else $error("receive and transmit word events coincide");
   c_word_taken: cover property (take ##[1:400] take);
   c_overrun: cover property (evt_set[E_OVERRUN]);
   c_lockstep_word: cover property (lockstep_select && take);
   c_masked_word: cover property (word_evt && !slot_on);
   c_tx_word: cover property (lockstep_select && tx_word_evt);
endmodule // tnr_receiver

/* File: hw/tnr_pkg.sv */
// Purpose: Shared constants and types for the TDM network receiver
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Offsets are word aligned; one register per word
package tnr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CONTROL_TWO = 8'h00;
   localparam logic [7:0] OFF_CONTROL_STATUS = 8'h04;
   localparam logic [7:0] OFF_RX_DATA = 8'h08;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFF_RX_SLOT_MASK = 8'h14;
   localparam logic [7:0] OFF_FRAME_CFG = 8'h18;
   // control_two bit positions
   localparam int B_PORT_ENABLE = 0;
   localparam int B_RX_ON = 1;
   localparam int B_LOCKSTEP = 2;
   localparam int B_RX_IRQ_EN = 3;
   localparam int B_SYNC_INVERT = 4;
   localparam int B_SYNC_LENGTH = 5;
   localparam int B_SYNC_EARLY = 6;
   localparam int CTRL_BITS = 7;
   // control_status bit positions
   localparam int B_WORD_AVAIL = 0;
   localparam int B_FRAME_START = 1;
   localparam int B_ARMED = 2;
   localparam int B_SLOT_LSB = 8;
   // Sticky event bits of irq_status / irq_mask
   localparam int E_OVERRUN = 0;
   localparam int E_FRAME = 1;
   localparam int E_TX_WORD = 2;
   localparam int EVT_BITS = 3;
   // Frame structure
   localparam int WORD_BITS = 8;
   localparam int MAX_SLOTS = 8;
   localparam int SLOT_W = 3;
   localparam int BIT_W = 3;
   localparam logic [SLOT_W-1:0] SLOTS_M1_RST = 3'h4;
   localparam logic [MAX_SLOTS-1:0] SLOT_MASK_RST = 8'hff;
   localparam logic [CTRL_BITS-1:0] CTRL_RST = 7'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Serial pins as sampled, transmit and receive sides
   typedef struct packed {
      logic tx_fs;
      logic tx_clk;
      logic rx_fs;
      logic rx_clk;
      logic rx_data;
   } tnr_pins_t;
   localparam int PIN_W = 5;
endpackage

/* File: hw/tnr_sync.sv */
// Purpose: Two flip-flop synchroniser for asynchronous pins
// Assumes: Each bit is independent; no bus coherence needed
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module tnr_sync import tnr_pkg::*; #(
   parameter int W = PIN_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   genvar i;
   // One pair of flops per pin
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta <= async_in[i];
               sync_out[i] <= meta;
            end
         end
      end
   endgenerate
endmodule // tnr_sync

/* File: hw/tnr_edge.sv */
// Purpose: Rising and falling edge finder on synchronised levels
// Assumes: Inputs already resynchronised to aclk
// Notes: Outputs are one-cycle pulses
`timescale 1ns/10ps
module tnr_edge import tnr_pkg::*; #(
   parameter int W = PIN_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] prev;
   // Last level, to compare against
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev <= '0;
      end else begin
         prev <= level;
      end
   end
   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule // tnr_edge

/* File: verif/tnr_codec.sv */
// Purpose: Behavioural codec driving the receive side of a TDM link
// Assumes: Five 8-bit slots a frame, one-bit frame sync, 160 ns bit period
// Notes: Bit clock stands still between frames, as a burst-clocked codec does
`timescale 1ns/10ps
module tnr_codec #(
   parameter int N = 5
) (
   input wire logic start,
   input wire logic [N*8-1:0] words,
   output logic bclk,
   output logic fsync,
   output logic sdata,
   output logic busy
);
   // Idle levels at time zero
   initial begin
      bclk = 1'b0;
      fsync = 1'b0;
      sdata = 1'b0;
      busy = 1'b0;
   end

   // One frame per start pulse; data and sync change on the rising edge
   always @(posedge start) begin
      busy = 1'b1;
      #7;
      for (int i = 0; i < N * 8; i++) begin
         bclk = 1'b1;
         fsync = (i == 0);
         sdata = words[8 * (i / 8) + 7 - i % 8];
         #80 bclk = 1'b0;
         #80;
      end
      // Released line: inverse of last bit, so stale data cannot match
      sdata = ~sdata;
      fsync = 1'b0;
      busy = 1'b0;
   end
endmodule // tnr_codec

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the TDM network receiver
// Assumes: Codec model drives the serial pins, bench is the bus master
// Notes: Seeded random slot data mixed with fixed corner patterns
`timescale 1ns/10ps
module tb import tnr_pkg::*; ;
   localparam logic [31:0] PE = 32'h1 << B_PORT_ENABLE;
   localparam logic [31:0] ON = 32'h1 << B_RX_ON;
   localparam logic [31:0] IE = 32'h1 << B_RX_IRQ_EN;
   localparam logic [31:0] LK = 32'h1 << B_LOCKSTEP;
   localparam logic [31:0] SL = 32'h1 << B_SYNC_LENGTH;
   logic aclk, aresetn, go, lock_mode, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [39:0] words;
   logic c_clk, c_fs, c_dat, c_busy;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;

   // In lockstep the codec feeds the transmit pins, rx clock held still
   tnr_receiver i_tnr_receiver (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rx_bit_clock(lock_mode ? 1'b0 : c_clk), .rx_frame_sync(lock_mode ? c_clk : c_fs),
      .rx_data_pin(c_dat), .tx_bit_clock(lock_mode ? c_clk : 1'b0),
      .tx_frame_sync(lock_mode ? c_fs : 1'b0), .irq(irq));

   tnr_codec i_tnr_codec (.start(go), .words(words), .bclk(c_clk), .fsync(c_fs),
      .sdata(c_dat), .busy(c_busy));

   // 50 MHz system clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic report_and_stop();
      if (errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // Address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      chk_resp("bresp", er, bresp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      v = rdata;
      chk_resp("rresp", er, rresp);
   endtask

   task automatic play(input logic [39:0] w);
      words <= w;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
   endtask

   // Codec done plus synchroniser latency
   task automatic finish_frame();
      while (c_busy === 1'b1) @(posedge aclk);
      repeat (12) @(posedge aclk);
   endtask

   // Serve each unmasked slot from its interrupt; masked slots must stay silent
   task automatic rx_frame(input logic [39:0] w, input logic [7:0] m);
      int n;
      play(w);
      for (int s = 0; s < 5; s++) begin
         if (m[s]) begin
            n = 0;
            while (irq !== 1'b1 && n < 400) begin
               @(posedge aclk);
               n++;
            end
            chk("irq_wait", 32'h1, {31'h0, irq});
            rd(OFF_RX_DATA, RESP_OKAY, d);
            chk("rx_data", {24'h0, w[8*s +: 8]}, d);
            chk("irq_after_read", 32'h0, {31'h0, irq});
         end
      end
      finish_frame();
      rd(OFF_CONTROL_STATUS, RESP_OKAY, d);
      chk("word_avail", 32'h0, {31'h0, d[B_WORD_AVAIL]});
      chk("frame_start_flag", 32'h1, {31'h0, d[B_FRAME_START]});
   endtask

   // Hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      aresetn = 1'b0;
      go = 1'b0;
      lock_mode = 1'b0;
      words = 40'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      void'($urandom(32'h56ea));
      // Reset values, unmapped and read-only places
      rd(OFF_CONTROL_TWO, RESP_OKAY, d);
      chk("control_two", 32'(CTRL_RST), d);
      rd(OFF_RX_SLOT_MASK, RESP_OKAY, d);
      chk("rx_slot_mask", 32'(SLOT_MASK_RST), d);
      rd(OFF_FRAME_CFG, RESP_OKAY, d);
      chk("frame_cfg", 32'(SLOTS_M1_RST), d);
      rd(OFF_IRQ_MASK, RESP_OKAY, d);
      chk("irq_mask", 32'h0, d);
      rd(8'h40, RESP_SLVERR, d);
      chk("unmapped", 32'h0, d);
      wr(OFF_RX_DATA, 32'h5a, RESP_SLVERR);
      // rx_on without port_enable: nothing received
      wr(OFF_CONTROL_TWO, ON | IE | SL, RESP_OKAY);
      play(40'h11_22_33_44_55);
      finish_frame();
      rd(OFF_CONTROL_STATUS, RESP_OKAY, d);
      chk("word_avail_off", 32'h0, {31'h0, d[B_WORD_AVAIL]});
      chk("irq_off", 32'h0, {31'h0, irq});
      // Enable sequence, rx_on raised in mid-frame: waits for next sync
      wr(OFF_CONTROL_TWO, PE | IE | SL, RESP_OKAY);
      play(40'h66_77_88_99_aa);
      repeat (120) @(posedge aclk);
      wr(OFF_CONTROL_TWO, PE | ON | IE | SL, RESP_OKAY);
      finish_frame();
      rd(OFF_CONTROL_STATUS, RESP_OKAY, d);
      chk("word_avail_mid", 32'h0, {31'h0, d[B_WORD_AVAIL]});
      // Corner patterns, then back-to-back random frames
      rx_frame(40'h80_01_ff_00_a5, 8'h1f);
      rx_frame(40'({$urandom(), $urandom()}), 8'h1f);
      rx_frame(40'({$urandom(), $urandom()}), 8'h1f);
      // Slot mask: only slots 0 and 2 delivered
      wr(OFF_RX_SLOT_MASK, 32'h05, RESP_OKAY);
      rx_frame(40'({$urandom(), $urandom()}), 8'h05);
      wr(OFF_RX_SLOT_MASK, 32'hff, RESP_OKAY);
      // No reads: overrun, masked then unmasked interrupt, W1C clear
      wr(OFF_IRQ_STATUS, 32'h7, RESP_OKAY);
      wr(OFF_CONTROL_TWO, PE | ON | SL, RESP_OKAY);
      play(40'hc3_3c_0f_f0_96);
      finish_frame();
      rd(OFF_IRQ_STATUS, RESP_OKAY, d);
      chk("overrun", 32'h1, {31'h0, d[E_OVERRUN]});
      chk("tx_evt_async", 32'h0, {31'h0, d[E_TX_WORD]});
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(OFF_IRQ_MASK, 32'h1 << E_OVERRUN, RESP_OKAY);
      chk("irq_unmasked", 32'h1, {31'h0, irq});
      rd(OFF_RX_DATA, RESP_OKAY, d);
      chk("rx_data_last", 32'hc3, d);
      wr(OFF_IRQ_STATUS, 32'h1 << E_OVERRUN, RESP_OKAY);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      rd(OFF_CONTROL_STATUS, RESP_OKAY, d);
      chk("word_avail_read", 32'h0, {31'h0, d[B_WORD_AVAIL]});
      wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
      // Lockstep: receiver framed by the transmit clock and sync
      wr(OFF_IRQ_STATUS, 32'h7, RESP_OKAY);
      lock_mode <= 1'b1;
      wr(OFF_CONTROL_TWO, PE | ON | IE | SL | LK, RESP_OKAY);
      rx_frame(40'({$urandom(), $urandom()}), 8'h1f);
      rd(OFF_IRQ_STATUS, RESP_OKAY, d);
      chk("tx_evt_lock", 32'h1, {31'h0, d[E_TX_WORD]});
      // Single interrupt set: transmit event alone raises irq, W1C clear drops it
      wr(OFF_IRQ_MASK, 32'h1 << E_TX_WORD, RESP_OKAY);
      chk("irq_tx_only", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_STATUS, 32'h1 << E_TX_WORD, RESP_OKAY);
      chk("irq_tx_cleared", 32'h0, {31'h0, irq});
      report_and_stop();
   end
endmodule // tb
